// [logic/pdw_top.sv]
// Port debounce and wake block: change detector on the four-pin switch
// port plus the external interrupt pin, with an Avalon-MM register slave.
// Assumes all pins are synchronous-safe after two flops and one 250 MHz clock.
//
// Implementation choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module pdw_top #(
    parameter int unsigned CYC_PER_TICK = pdw_pkg::CYC_PER_TICK
) (
    // Clock and reset
    input  wire logic                          i_sys_clk,
    input  wire logic                          i_sys_rst,
    // Avalon-MM slave
    input  wire pdw_pkg::pdw_avs_req_t         i_avs,
    output logic [31:0]                        o_avs_readdata,
    output logic                               o_avs_waitrequest,
    // Switch port pins
    input  wire logic [pdw_pkg::PORT_W-1:0]    i_switch_port,
    output logic [pdw_pkg::PORT_W-1:0]         o_port_dir,
    output logic                               o_pull_low_en,
    // External interrupt pin
    input  wire logic                          i_ext_int,
    // Wake and interrupt requests
    output pdw_pkg::pdw_wake_t                 o_wake
);
    import pdw_pkg::*;

    typedef struct packed {
        pdw_bus_state_t      bus;
        logic                waitreq;
        logic [31:0]         rdata;
        logic [4:0]          setup;
        logic                pull_low;
        logic [1:0]          sel;
        logic [PORT_W-1:0]   arm_mask;
        logic [PORT_W-1:0]   ref_lvl;
        logic [PORT_W-1:0]   cand;
        logic [1:0]          stable_cnt;
        logic                port_change_flag;
        logic [PORT_W-1:0]   in_s1;
        logic [PORT_W-1:0]   in_s2;
        logic                ext_s1;
        logic                ext_s2;
        logic                ext_d;
        logic [3:0]          enable;
        logic                ext_flag;
        pdw_wake_t           wake;
    } pdw_state_t;

    pdw_state_t           st_reg;
    pdw_state_t           st_next;
    logic [NUM_TAPS-1:0]  tap_pulse;
    logic                 deb_tick;
    logic                 deb_run;
    logic                 arm_go;
    logic                 setup_go;
    logic                 set_evt;
    logic                 ext_edge;
    logic                 wr_go;
    logic [PORT_W-1:0]    mon_now;

    // Maps the select code to its tap; the unused code falls back to the slowest
    function automatic logic pick_tap(input logic [1:0] sel, input logic [NUM_TAPS-1:0] taps);
        unique case (sel)
            SEL_EIGHT: return taps[TAP_IDX_EIGHT];
            SEL_SIX:   return taps[TAP_IDX_SIX];
            default:   return taps[TAP_IDX_TEN];
        endcase
    endfunction : pick_tap

    // Write strobe to one register; only the low byte lane carries fields
    function automatic logic reg_wr(input pdw_avs_req_t req, input logic [4:0] ofs);
        return req.write && req.byteenable[0] && (req.address == ofs);
    endfunction : reg_wr

    // ==========================================================
    // Debounce clock
    // ==========================================================
    assign deb_run = !st_reg.port_change_flag;

    pdw_prediv #(
        .CYC_PER_TICK (CYC_PER_TICK)
    ) pdw_prediv_i (
        .i_sys_clk   (i_sys_clk),
        .i_sys_rst   (i_sys_rst),
        .i_run       (deb_run),
        .i_restart   (arm_go),
        .o_tap_pulse (tap_pulse)
    );

    assign deb_tick = pick_tap(st_reg.sel, tap_pulse);

    // ==========================================================
    // Bus strobes and detection terms
    // ==========================================================
    // Writes take effect only at the edge where waitrequest is seen low
    assign wr_go    = (st_reg.bus == BUS_ACK) && i_avs.write;
    assign arm_go   = wr_go && reg_wr(i_avs, OFS_ARM);
    assign setup_go = wr_go && reg_wr(i_avs, OFS_PORT_SETUP);
    // Output pins are masked off before comparison
    assign mon_now  = st_reg.in_s2 & st_reg.arm_mask & ~st_reg.setup[PORT_W-1:0];
    assign set_evt  = deb_tick && !st_reg.port_change_flag && (mon_now != st_reg.ref_lvl)
                      && (mon_now == st_reg.cand)
                      && (st_reg.stable_cnt == STABLE_TICKS - 2'h1);
    assign ext_edge = st_reg.enable[EN_EXT_RISE] ? (st_reg.ext_s2 && !st_reg.ext_d)
                                                 : (!st_reg.ext_s2 && st_reg.ext_d);

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        st_next = st_reg;

        // Synchronisers: the first stage feeds only the second
        st_next.in_s1  = i_switch_port;
        st_next.in_s2  = st_reg.in_s1;
        st_next.ext_s1 = i_ext_int;
        st_next.ext_s2 = st_reg.ext_s1;
        st_next.ext_d  = st_reg.ext_s2;

        // Bus handshake: one wait cycle, then one cycle of waitrequest low
        unique case (st_reg.bus)
            BUS_IDLE: begin
                if (i_avs.read || i_avs.write) begin
                    st_next.bus     = BUS_ACK;
                    st_next.waitreq = 1'b0;
                    st_next.rdata   = '0;
                    unique case (i_avs.address)
                        OFS_PORT_SETUP: st_next.rdata[4:0] = st_reg.setup;
                        OFS_DEB_SEL:    st_next.rdata[1:0] = st_reg.sel;
                        OFS_ARM:        st_next.rdata[PORT_W-1:0] = st_reg.arm_mask;
                        OFS_ENABLE:     st_next.rdata[3:0] = st_reg.enable;
                        OFS_STATUS: begin
                            st_next.rdata[ST_PORT_FLAG] = st_reg.port_change_flag;
                            st_next.rdata[ST_EXT_FLAG]  = st_reg.ext_flag;
                            st_next.rdata[ST_RUNNING]   = deb_run;
                            st_next.rdata[ST_INPUT_LSB +: PORT_W] = st_reg.in_s2;
                        end
                        default: st_next.rdata = '0;
                    endcase
                end
            end
            BUS_ACK: begin
                st_next.bus     = BUS_IDLE;
                st_next.waitreq = 1'b1;
            end
        endcase

        // Register writes
        if (setup_go) begin
            st_next.setup    = i_avs.writedata[4:0];
            st_next.pull_low = (i_avs.writedata[4:0] == SETUP_PULL_LOW);
        end
        if (wr_go && reg_wr(i_avs, OFS_DEB_SEL)) begin
            st_next.sel = i_avs.writedata[1:0];
        end
        if (wr_go && reg_wr(i_avs, OFS_ENABLE)) begin
            st_next.enable = i_avs.writedata[3:0];
        end

        // Change detection on debounce ticks
        if (deb_tick && !st_reg.port_change_flag) begin
            if (mon_now == st_reg.ref_lvl) begin
                st_next.stable_cnt = '0;
            end else if (mon_now != st_reg.cand) begin
                st_next.cand       = mon_now;
                st_next.stable_cnt = 2'h1;
            end else begin
                st_next.stable_cnt = st_reg.stable_cnt + 2'h1;
            end
        end
        if (arm_go) begin
            // Arming samples the present levels as the new reference
            st_next.arm_mask   = i_avs.writedata[PORT_W-1:0];
            st_next.ref_lvl    = st_reg.in_s2 & i_avs.writedata[PORT_W-1:0]
                                 & ~st_reg.setup[PORT_W-1:0];
            st_next.cand       = st_next.ref_lvl;
            st_next.stable_cnt = '0;
            st_next.port_change_flag = 1'b0;
        end
        if (set_evt) begin
            // Set wins over a coinciding arm
            st_next.port_change_flag = 1'b1;
            st_next.ref_lvl    = mon_now;
            st_next.stable_cnt = '0;
        end

        // External pin flag: write one to clear, a coinciding edge wins
        if (wr_go && reg_wr(i_avs, OFS_STATUS) && i_avs.writedata[ST_EXT_FLAG]) begin
            st_next.ext_flag = 1'b0;
        end
        if (ext_edge) begin
            st_next.ext_flag = 1'b1;
        end

        // Wake outputs, each one register behind its cause
        st_next.wake.port_halt_release_req = st_reg.port_change_flag;
        st_next.wake.port_irq = st_reg.port_change_flag && st_reg.enable[EN_PORT_IRQ];
        st_next.wake.ext_halt_release_req  = st_reg.ext_flag;
        st_next.wake.start_cond2 = st_reg.ext_flag && st_reg.enable[EN_EXT_HALT];
        st_next.wake.ext_irq     = st_reg.ext_flag && st_reg.enable[EN_EXT_IRQ];
    end

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_reg         <= '0;
            st_reg.bus     <= BUS_IDLE;
            st_reg.waitreq <= 1'b1;
            st_reg.setup   <= SETUP_RESET;
            st_reg.sel     <= SEL_RESET;
            st_reg.enable  <= ENABLE_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign o_avs_readdata    = st_reg.rdata;
    assign o_avs_waitrequest = st_reg.waitreq;
    assign o_port_dir        = st_reg.setup[PORT_W-1:0];
    // Pull-low follows the last setup operand
    assign o_pull_low_en     = st_reg.pull_low;
    assign o_wake            = st_reg.wake;

    // ==========================================================
    // Assertions
    // ==========================================================
    property p_pull_low;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        setup_go |=> (o_pull_low_en == ($past(i_avs.writedata[4:0]) == SETUP_PULL_LOW));
    endproperty
    a_pull_low: assert property (p_pull_low) else $error("pull-low mismatch");

    property p_tap_pick;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (st_reg.sel == SEL_SIX) |-> (deb_tick == tap_pulse[TAP_IDX_SIX]);
    endproperty
    a_tap_pick: assert property (p_tap_pick) else $error("wrong debounce tap");

    property p_out_masked;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (mon_now & st_reg.setup[PORT_W-1:0]) == '0;
    endproperty
    a_out_masked: assert property (p_out_masked) else $error("output pin monitored");

    property p_two_ticks;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        $rose(st_reg.port_change_flag) |-> $past(deb_tick)
            && ($past(st_reg.stable_cnt) == STABLE_TICKS - 2'h1);
    endproperty
    a_two_ticks: assert property (p_two_ticks) else $error("flag set too early");

    property p_clk_stop;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (st_reg.port_change_flag ##1 st_reg.port_change_flag) |-> (tap_pulse == '0);
    endproperty
    a_clk_stop: assert property (p_clk_stop) else $error("debounce clock ran");

    property p_arm_clear;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (arm_go && !set_evt) |=> !st_reg.port_change_flag;
    endproperty
    a_arm_clear: assert property (p_arm_clear) else $error("arm did not clear");

    property p_port_hrr;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        st_reg.port_change_flag |=> o_wake.port_halt_release_req;
    endproperty
    a_port_hrr: assert property (p_port_hrr) else $error("port wake missing");

    property p_port_irq;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        o_wake.port_irq |-> $past(st_reg.port_change_flag && st_reg.enable[EN_PORT_IRQ]);
    endproperty
    a_port_irq: assert property (p_port_irq) else $error("stray port irq");

    property p_ext_edge;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        ext_edge |=> st_reg.ext_flag ##1 o_wake.ext_halt_release_req;
    endproperty
    a_ext_edge: assert property (p_ext_edge) else $error("ext edge lost");

    property p_start2;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (st_reg.ext_flag && st_reg.enable[EN_EXT_HALT]) |=> o_wake.start_cond2;
    endproperty
    a_start2: assert property (p_start2) else $error("start flag 2 missing");

    property p_ext_irq;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        o_wake.ext_irq |-> $past(st_reg.ext_flag) && $past(st_reg.enable[EN_EXT_IRQ]);
    endproperty
    a_ext_irq: assert property (p_ext_irq) else $error("stray ext irq");

    property p_sync;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        st_reg.ext_d == $past(st_reg.ext_s1, 2);
    endproperty
    a_sync: assert property (p_sync) else $error("sync chain broken");

    property p_cv_flag;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        $rose(st_reg.port_change_flag);
    endproperty
    c_cv_flag: cover property (p_cv_flag);

    property p_cv_ext;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        $rose(o_wake.ext_irq);
    endproperty
    c_cv_ext: cover property (p_cv_ext);

    property p_cv_rearm;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        st_reg.port_change_flag ##1 arm_go;
    endproperty
    c_cv_rearm: cover property (p_cv_rearm);

endmodule : pdw_top
`default_nettype wire

// [logic/pdw_pkg.sv]
// Shared constants and carrier types of the port debounce and wake block.
// Assumes a single 250 MHz system clock and a 32-bit Avalon-MM slave port.
package pdw_pkg;

    // ==========================================================
    // Clocking and pre-divider
    // ==========================================================
    localparam int unsigned SYS_CLK_HZ   = 250_000_000;
    localparam int unsigned BASE_TICK_HZ = 32_768;
    // System cycles per pre-divider input tick, rounded down
    localparam int unsigned CYC_PER_TICK = SYS_CLK_HZ / BASE_TICK_HZ;
    localparam int unsigned PH_CNT_W     = 10;
    // Tap numbers: a tap k pulses once every 2**k input ticks
    localparam int unsigned TAP_TEN      = 10;
    localparam int unsigned TAP_EIGHT    = 8;
    localparam int unsigned TAP_SIX      = 6;
    localparam int unsigned NUM_TAPS     = 3;
    localparam int unsigned TAP_IDX_TEN  = 0;
    localparam int unsigned TAP_IDX_EIGHT = 1;
    localparam int unsigned TAP_IDX_SIX  = 2;

    // ==========================================================
    // Debounce
    // ==========================================================
    localparam int unsigned PORT_W       = 4;
    localparam logic [1:0]  STABLE_TICKS = 2'h2;
    localparam logic [1:0]  SEL_TEN      = 2'h0;
    localparam logic [1:0]  SEL_EIGHT    = 2'h1;
    localparam logic [1:0]  SEL_SIX      = 2'h2;
    localparam logic [1:0]  SEL_RESET    = SEL_TEN;
    localparam logic [4:0]  SETUP_PULL_LOW = 5'h10;
    localparam logic [4:0]  SETUP_RESET  = 5'h00;

    // ==========================================================
    // Register map (byte addresses)
    // ==========================================================
    localparam int unsigned AVS_ADDR_W   = 5;
    localparam logic [4:0]  OFS_PORT_SETUP = 5'h00;
    localparam logic [4:0]  OFS_DEB_SEL  = 5'h04;
    localparam logic [4:0]  OFS_ARM      = 5'h08;
    localparam logic [4:0]  OFS_ENABLE   = 5'h0c;
    localparam logic [4:0]  OFS_STATUS   = 5'h10;
    // ENABLE fields
    localparam int unsigned EN_PORT_IRQ  = 0;
    localparam int unsigned EN_EXT_HALT  = 1;
    localparam int unsigned EN_EXT_IRQ   = 2;
    localparam int unsigned EN_EXT_RISE  = 3;
    localparam logic [3:0]  ENABLE_RESET = 4'h8;
    // STATUS fields
    localparam int unsigned ST_PORT_FLAG = 0;
    localparam int unsigned ST_EXT_FLAG  = 1;
    localparam int unsigned ST_RUNNING   = 2;
    localparam int unsigned ST_INPUT_LSB = 8;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic                  read;
        logic                  write;
        logic [AVS_ADDR_W-1:0] address;
        logic [31:0]           writedata;
        logic [3:0]            byteenable;
    } pdw_avs_req_t;

    typedef struct packed {
        logic port_halt_release_req;
        logic port_irq;
        logic ext_halt_release_req;
        logic start_cond2;
        logic ext_irq;
    } pdw_wake_t;

    typedef enum logic {BUS_IDLE, BUS_ACK} pdw_bus_state_t;

endpackage : pdw_pkg

// [logic/pdw_prediv.sv]
// Pre-divider: turns the system clock into the three debounce tap pulses.
// Assumes one clock; the tap pulses are one system cycle wide.
`timescale 1ns/1ps
`default_nettype none
module pdw_prediv #(
    parameter int unsigned CYC_PER_TICK = pdw_pkg::CYC_PER_TICK
) (
    // Clock and reset
    input  wire logic                          i_sys_clk,
    input  wire logic                          i_sys_rst,
    // Control
    input  wire logic                          i_run,
    input  wire logic                          i_restart,
    // Tap pulses
    output logic [pdw_pkg::NUM_TAPS-1:0]       o_tap_pulse
);
    import pdw_pkg::*;

    typedef struct packed {
        logic [15:0]         base_cnt;
        logic [PH_CNT_W-1:0] ph_cnt;
        logic [NUM_TAPS-1:0] taps;
    } pdw_div_t;

    pdw_div_t st_reg;
    pdw_div_t st_next;

    // A tap fires when its low k bits roll over on an input tick
    function automatic logic tap_hit(input logic [PH_CNT_W-1:0] cnt, input int unsigned k);
        logic [PH_CNT_W-1:0] mask;
        mask = PH_CNT_W'((1 << k) - 1);
        return (cnt & mask) == mask;
    endfunction : tap_hit

    // ==========================================================
    // Divider
    // ==========================================================
    always_comb begin
        logic base_tick;
        base_tick = 1'b0;
        st_next   = st_reg;
        st_next.taps = '0;
        if (i_restart) begin
            // Restart from a clean phase so the first period is full length
            st_next.base_cnt = '0;
            st_next.ph_cnt   = '0;
        end else if (i_run) begin
            base_tick = (st_reg.base_cnt == 16'(CYC_PER_TICK - 1));
            st_next.base_cnt = base_tick ? '0 : st_reg.base_cnt + 16'h0001;
            if (base_tick) begin
                st_next.taps[TAP_IDX_TEN]   = tap_hit(st_reg.ph_cnt, TAP_TEN);
                st_next.taps[TAP_IDX_EIGHT] = tap_hit(st_reg.ph_cnt, TAP_EIGHT);
                st_next.taps[TAP_IDX_SIX]   = tap_hit(st_reg.ph_cnt, TAP_SIX);
                st_next.ph_cnt = st_reg.ph_cnt + PH_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_tap_pulse = st_reg.taps;

endmodule : pdw_prediv
`default_nettype wire

// [tb/pdw_switch_model.sv]
// Switch contacts and interrupt source in front of the switch port.
// Assumes the bench sets levels just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module pdw_switch_model (
    // Clock
    input  wire logic       i_sys_clk,
    // Wanted levels
    input  wire logic [3:0] i_level,
    input  wire logic       i_ext_level,
    // Pins
    output logic [3:0]      o_switch_port,
    output logic            o_ext_int
);
    // ==========================================
    // Chatter: six cycles of old and new levels
    logic [3:0] last_reg = 4'h0;
    logic [3:0] old_reg  = 4'h0;
    logic [2:0] cnt_reg  = 3'h0;
    always @(posedge i_sys_clk) begin
        if (i_level != last_reg) begin
            cnt_reg <= 3'h6;
            old_reg <= last_reg;
        end else if (cnt_reg != 3'h0) begin
            cnt_reg <= cnt_reg - 3'h1;
        end
        last_reg <= i_level;
    end
    assign o_switch_port = cnt_reg[0] ? old_reg : i_level;
    // Clean edges keep the interrupt latency exact
    assign o_ext_int     = i_ext_level;
endmodule : pdw_switch_model
`default_nettype wire

// [tb/test_port_debounce_wake.sv]
// Self-checking bench of the port debounce and wake block.
// Assumes one wait cycle per bus transfer and a shortened pre-divider.
`timescale 1ns/1ps
`default_nettype none
module test_port_debounce_wake;
    import pdw_pkg::*;
    // ==========================================
    // Signals
    localparam int unsigned CPP = 4;
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    pdw_avs_req_t req = '0;
    logic [31:0]  rdat;
    logic         wreq;
    logic [3:0]   lvl = 4'h0;
    logic         ext = 1'b0;
    logic [3:0]   pins;
    logic         pext;
    logic [3:0]   dir;
    logic         pl;
    pdw_wake_t    wk;
    logic [63:0]  exp_q[$];
    logic [63:0]  e;
    logic [15:0]  rnd = 16'h1;
    int           n_fail = 0;
    int           cmp_count = 0;
    int           cyc = 0;
    int           n;

    always #2 clk = ~clk;

    pdw_top #(.CYC_PER_TICK(CPP)) pdw_top_i (
        .i_sys_clk(clk), .i_sys_rst(rst), .i_avs(req), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wreq), .i_switch_port(pins), .o_port_dir(dir),
        .o_pull_low_en(pl), .i_ext_int(pext), .o_wake(wk));
    pdw_switch_model pdw_switch_model_i (
        .i_sys_clk(clk), .i_level(lvl), .i_ext_level(ext),
        .o_switch_port(pins), .o_ext_int(pext));

    // ==========================================
    // Tasks
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic chk(input logic [31:0] a, input logic [31:0] x);
        cmp_count++;
        if (a !== x) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, a, x);
        end
    endtask : chk

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    // Request held until waitrequest is sampled low, then one idle edge
    task automatic bus(input logic r, input logic [4:0] a, input logic [31:0] d,
                       input logic [3:0] b);
        req <= '{read: r, write: !r, address: a, writedata: d, byteenable: b};
        @(posedge clk);
        while (wreq !== 1'b0) begin
            @(posedge clk);
        end
        req <= '0;
        @(posedge clk);
    endtask : bus

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b0, a, d, 4'hf);
    endtask : wr

    task automatic rd(input logic [4:0] a, input logic [31:0] x, input logic [31:0] m);
        exp_q.push_back({m, x});
        bus(1'b1, a, 32'h0, 4'hf);
    endtask : rd

    task automatic wt(input int i);
        n = 0;
        while (wk[i] !== 1'b1 && n < 20000) begin
            @(posedge clk);
            n++;
        end
    endtask : wt

    // ==========================================
    // Read monitor and timeout
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (req.read && wreq === 1'b0) begin
            e = exp_q.pop_front();
            chk(rdat & e[63:32], e[31:0]);
        end
        if (cyc == 60000) begin
            n_fail++;
            wrap_up();
        end
    end

    initial begin
        int t;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(32'(wk), 32'h0);
        rd(OFS_ENABLE, 32'h8, '1);
        rd(OFS_DEB_SEL, 32'h0, '1);
        rd(OFS_PORT_SETUP, 32'h0, '1);
        rd(5'h14, 32'h0, '1);
        wr(OFS_DEB_SEL, 32'h3);
        rd(OFS_DEB_SEL, 32'h3, '1);
        repeat (3) begin
            rnd = lfsr(rnd);
            wr(OFS_ENABLE, {28'h0, rnd[3:0]});
            rd(OFS_ENABLE, {28'h0, rnd[3:0]}, '1);
        end
        bus(1'b0, OFS_ENABLE, 32'h0, 4'he);
        rd(OFS_ENABLE, {28'h0, rnd[3:0]}, '1);
        wr(OFS_PORT_SETUP, 32'h10);
        chk(32'(pl), 32'h1);
        wr(OFS_PORT_SETUP, 32'h1);
        chk(32'({pl, dir}), 32'h1);
        wr(OFS_DEB_SEL, 32'h2);
        wr(OFS_ARM, 32'hf);
        lvl <= 4'h1;
        repeat (800) @(posedge clk);
        rd(OFS_STATUS, 32'h4, 32'h7);
        for (int s = 0; s < 3; s++) begin
            t = CPP << (10 - 2 * s);
            wr(OFS_PORT_SETUP, 32'h0);
            wr(OFS_DEB_SEL, 32'(s));
            wr(OFS_ENABLE, 32'(s & 1));
            wr(OFS_ARM, 32'hf);
            lvl <= {3'h0, ~lvl[0]};
            wt(4);
            chk(32'(n >= 2 * t && n <= 2 * t + 4), 32'h1);
            chk(32'(wk.port_irq), 32'(s & 1));
            rd(OFS_STATUS, {20'h0, lvl, 8'h1}, 32'hf07);
            wr(OFS_ARM, 32'hf);
            rd(OFS_STATUS, 32'h4, 32'h5);
            chk(32'(wk.port_halt_release_req), 32'h0);
        end
        wr(OFS_ENABLE, 32'he);
        ext <= 1'b1;
        wt(2);
        chk(32'(n), 32'h5);
        chk(32'(wk[1:0]), 32'h3);
        rd(OFS_STATUS, 32'h2, 32'h2);
        wr(OFS_STATUS, 32'h2);
        rd(OFS_STATUS, 32'h0, 32'h2);
        wr(OFS_ENABLE, 32'h2);
        ext <= 1'b0;
        wt(2);
        chk(32'(wk[1:0]), 32'h2);
        wrap_up();
    end
endmodule : test_port_debounce_wake
`default_nettype wire
